// File: core/imdu_map.svh
`ifndef IMDU_MAP_SVH
`define IMDU_MAP_SVH
// ==========================================================
// register addresses
`define IMDU_ADDR_SRC_LO   16'hff80
`define IMDU_ADDR_SRC_HI   16'hff81
`define IMDU_ADDR_DLO_LO   16'hff82
`define IMDU_ADDR_DLO_HI   16'hff83
`define IMDU_ADDR_DHI_LO   16'hff84
`define IMDU_ADDR_DHI_HI   16'hff85
`define IMDU_ADDR_CTRL     16'hff86
// ==========================================================
// control register bit positions
`define IMDU_BIT_START     0
`define IMDU_BIT_ZERO      1
`define IMDU_BIT_OVF       2
`define IMDU_BIT_NEG       3
// ==========================================================
// timing and reset values
`define IMDU_OP_CYCLES     4'ha
`define IMDU_CNT_ZERO      4'h0
`define IMDU_NIB_ZERO      4'h0
`endif

// File: core/imdu_pkg.sv
// ==========================================================
// types of the multiply/divide unit
package imdu_pkg;
   typedef enum logic [0:0] {
      IMDU_IDLE = 1'b0,
      IMDU_BUSY = 1'b1
   } imdu_state_t;
endpackage

// File: core/imdu_unit.sv
// Overview of operation
// RULE1 - operands split into nibbles, low nibble at lower address
// RULE2 - source register is multiplier or divisor
// RULE3 - source register holds its value until rewritten
// RULE4 - any control write starts; 1 divides, 0 multiplies
// RULE5 - start bit reads 1 while running, 0 once results load
// RULE6 - low destination byte taken at start; done in ten cycles
// RULE7 - product low byte or quotient loads destination low byte
// RULE8 - division overflow leaves dividend low byte in place
// RULE9 - multiply ignores old high byte, loads product high byte
// RULE10 - divide takes high byte as dividend; remainder loaded after
// RULE11 - division overflow leaves dividend high byte in place
// RULE12 - negative flag shows result msb, read only
// RULE13 - overflow flag set on division overflow, cleared by multiply
// RULE14 - zero flag shows zero result, read only
// RULE15 - reset clears start bit and flags; data registers unreset
// RULE16 - cpu keeps off results and flags during the ten cycles
// RULE17 - all operands treated as unsigned
// RULE18 - multiply: negative is high byte bit 7, zero on 16-bit zero
// RULE19 - divide: negative is quotient bit 7, zero on zero quotient
// RULE20 - zero divisor counts as overflow, dividend kept
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "imdu_map.svh"
// ==========================================================
// programming model
//   the cpu sees seven nibble registers in a row; every byte is
//   split low nibble first, so a byte write takes two strobes
//   source operand: multiplier or divisor, kept between runs
//   destination low byte: multiplicand or low dividend byte
//   destination high byte: high dividend byte, unused by multiply
//   control nibble: bit 3 negative, bit 2 overflow, bit 1 zero,
//   bit 0 mode on write and busy on read
//   addresses outside the seven registers read zero and drop writes
//
// ==========================================================
// one operation, cycle by cycle
//   cycle 0   control write; the mode comes from wdata bit 0
//   edge 0    operands are copied into the working latches
//   cycle 1   busy rises and stays high for ten cycles
//   edge 10   result and flags load on the same edge
//   cycle 11  busy reads back low; results may be read
//   the latency is fixed and does not depend on the operands
//
// ==========================================================
// hazards the cpu must keep in mind
//   reads of the destination or the flags while busy return the
//   values from before the start; the unit does not flag this
//   a bus write to the destination on the load edge is lost,
//   because the result has priority on that edge
//   a control write while busy restarts the run with whatever
//   the destination holds at that moment
//   flag bits written through the control nibble are dropped;
//   only bit 0 of a control write has any effect
//   the data registers have no reset value, so software must
//   load all operands before the first run after power up
//
// ==========================================================
// division overflow
//   a quotient wider than eight bits, or a zero divisor, leaves
//   both destination bytes holding the dividend and raises the
//   overflow flag; negative and zero then follow the kept low byte
//   a wide quotient can still be formed by software in two runs:
//   high dividend byte first, its remainder carried into the
//   high byte of the second run beside the low dividend byte
//   the flags only describe the last of the two runs
//
// ==========================================================
// implementation notes
//   the arithmetic is one combinational multiply and divide on
//   the latched operands; the ten cycle sequencer only decides
//   when the result is taken, which keeps the timing simple at
//   the cost of a long combinational path through the divider
//   operands are latched so that bus writes during the run do
//   not disturb the result that the cpu will read back
//   only the sequencer, the flags and the read data are reset
//   clock enable low freezes every register, the read data too,
//   so a frozen run resumes exactly where it stopped
module imdu_unit (
   // clock, reset and enable
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        clock_enable,
   // register port
   input  wire logic [15:0] addr,
   input  wire logic [3:0]  wdata,
   input  wire logic        wr_strobe,
   input  wire logic        rd_strobe,
   output logic      [3:0]  rdata,
   // status
   output logic             busy
);
   // ==========================================================
   // state
   imdu_pkg::imdu_state_t state_reg;
   logic [7:0] source_operand_reg;
   logic [7:0] dest_low_byte_reg;
   logic [7:0] dest_high_byte_reg;
   logic [7:0] op_lo_reg;
   logic [7:0] op_hi_reg;
   logic [7:0] op_src_reg;
   logic       op_div_reg;
   logic [3:0] cnt_reg;
   logic       negative_flag_reg;
   logic       overflow_flag_reg;
   logic       zero_flag_reg;
   logic       done;
   logic       start;
   logic [15:0] product;
   logic [15:0] dividend;
   logic [15:0] quot_full;
   logic [7:0]  remainder;
   logic        div_ovf;

   // address match helper
   function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
      hit = (a == ref_a);
   endfunction

   assign start = clock_enable && wr_strobe && hit(addr, `IMDU_ADDR_CTRL); // [RULE4]
   assign done  = clock_enable && (state_reg == imdu_pkg::IMDU_BUSY) && (cnt_reg == `IMDU_OP_CYCLES - 4'h1);
   assign busy  = (state_reg == imdu_pkg::IMDU_BUSY);

   // ==========================================================
   // arithmetic on latched unsigned operands
   assign product   = op_lo_reg * op_src_reg;                       // [RULE17] [RULE2]
   assign dividend  = {op_hi_reg, op_lo_reg};                       // [RULE10]
   assign quot_full = (op_src_reg == 8'h00) ? 16'hffff : dividend / {8'h00, op_src_reg};
   assign remainder = (op_src_reg == 8'h00) ? 8'h00 : 8'((dividend % {8'h00, op_src_reg}));
   assign div_ovf   = (op_src_reg == 8'h00) || (quot_full[15:8] != 8'h00); // [RULE20]

   // ==========================================================
   // sequencer: ten cycles from start to load
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= imdu_pkg::IMDU_IDLE;                          // [RULE15]
         cnt_reg   <= `IMDU_CNT_ZERO;
      end else if (clock_enable) begin
         if (start) begin
            state_reg <= imdu_pkg::IMDU_BUSY;                       // [RULE5]
            cnt_reg   <= `IMDU_CNT_ZERO;
         end else if (done) begin
            state_reg <= imdu_pkg::IMDU_IDLE;                       // [RULE5] [RULE6]
         end else if (busy) begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end

   // operand latch at start
   always_ff @(posedge clock) begin
      if (start) begin
         op_lo_reg  <= dest_low_byte_reg;                           // [RULE6]
         op_hi_reg  <= dest_high_byte_reg;                          // [RULE10]
         op_src_reg <= source_operand_reg;                          // [RULE2]
         op_div_reg <= wdata[`IMDU_BIT_START];                      // [RULE4]
      end
   end

   // ==========================================================
   // source register, no reset value
   always_ff @(posedge clock) begin
      if (clock_enable && wr_strobe) begin
         if (hit(addr, `IMDU_ADDR_SRC_LO))
            source_operand_reg[3:0] <= wdata;                       // [RULE1] [RULE3]
         if (hit(addr, `IMDU_ADDR_SRC_HI))
            source_operand_reg[7:4] <= wdata;                       // [RULE1]
      end
   end

   // destination registers: bus writes or result load
   always_ff @(posedge clock) begin
      if (done) begin
         if (!op_div_reg) begin
            dest_low_byte_reg  <= product[7:0];                     // [RULE7]
            dest_high_byte_reg <= product[15:8];                    // [RULE9]
         end else if (!div_ovf) begin
            dest_low_byte_reg  <= quot_full[7:0];                   // [RULE7]
            dest_high_byte_reg <= remainder;                        // [RULE10]
         end else begin
            dest_low_byte_reg  <= op_lo_reg;                        // [RULE8]
            dest_high_byte_reg <= op_hi_reg;                        // [RULE11]
         end
      end else if (clock_enable && wr_strobe) begin
         if (hit(addr, `IMDU_ADDR_DLO_LO)) dest_low_byte_reg[3:0]  <= wdata; // [RULE1]
         if (hit(addr, `IMDU_ADDR_DLO_HI)) dest_low_byte_reg[7:4]  <= wdata;
         if (hit(addr, `IMDU_ADDR_DHI_LO)) dest_high_byte_reg[3:0] <= wdata;
         if (hit(addr, `IMDU_ADDR_DHI_HI)) dest_high_byte_reg[7:4] <= wdata;
      end
   end

   // ==========================================================
   // flags, read only, updated with the result
   always_ff @(posedge clock) begin
      if (reset) begin
         negative_flag_reg <= 1'b0;                                 // [RULE15]
         overflow_flag_reg <= 1'b0;
         zero_flag_reg     <= 1'b0;
      end else if (done) begin
         if (!op_div_reg) begin
            negative_flag_reg <= product[15];                       // [RULE18] [RULE12]
            overflow_flag_reg <= 1'b0;                              // [RULE13]
            zero_flag_reg     <= (product == 16'h0000);             // [RULE18] [RULE14]
         end else if (!div_ovf) begin
            negative_flag_reg <= quot_full[7];                      // [RULE19] [RULE12]
            overflow_flag_reg <= 1'b0;                              // [RULE13]
            zero_flag_reg     <= (quot_full[7:0] == 8'h00);         // [RULE19] [RULE14]
         end else begin
            negative_flag_reg <= op_lo_reg[7];                      // [RULE19]
            overflow_flag_reg <= 1'b1;                              // [RULE13] [RULE20]
            zero_flag_reg     <= (op_lo_reg == 8'h00);              // [RULE19]
         end
      end
   end

   // ==========================================================
   // read data, one cycle after the strobe
   always_ff @(posedge clock) begin
      if (reset) begin
         rdata <= `IMDU_NIB_ZERO;
      end else if (clock_enable) begin
         rdata <= `IMDU_NIB_ZERO;
         if (rd_strobe) begin
            unique case (addr)
               `IMDU_ADDR_SRC_LO: rdata <= source_operand_reg[3:0];
               `IMDU_ADDR_SRC_HI: rdata <= source_operand_reg[7:4];
               `IMDU_ADDR_DLO_LO: rdata <= dest_low_byte_reg[3:0];
               `IMDU_ADDR_DLO_HI: rdata <= dest_low_byte_reg[7:4];
               `IMDU_ADDR_DHI_LO: rdata <= dest_high_byte_reg[3:0];
               `IMDU_ADDR_DHI_HI: rdata <= dest_high_byte_reg[7:4];
               `IMDU_ADDR_CTRL:   rdata <= {negative_flag_reg, overflow_flag_reg, zero_flag_reg, busy}; // [RULE5]
               default:           rdata <= `IMDU_NIB_ZERO;
            endcase
         end
      end
   end

   // ==========================================================
   // checks
   sequence start_s;
      start && !busy;
   endsequence

   sequence run_s;
      busy [*8];
   endsequence

   run_length_a : assert property (@(posedge clock) disable iff (reset || !clock_enable) // [RULE6]
      start_s |=> run_s ##1 busy ##1 busy ##1 !busy) else $error("operation length wrong");
   busy_high_a : assert property (@(posedge clock) disable iff (reset)
      start && clock_enable |=> busy) else $error("busy not set after start"); // [RULE5]
   mul_clear_ovf_a : assert property (@(posedge clock) disable iff (reset)
      done && !op_div_reg |=> !overflow_flag_reg) else $error("overflow after multiply"); // [RULE13]
   mul_result_a : assert property (@(posedge clock) disable iff (reset)
      done && !op_div_reg |=> {dest_high_byte_reg, dest_low_byte_reg} == $past(product)) else $error("bad product"); // [RULE9]
   div_keep_a : assert property (@(posedge clock) disable iff (reset)
      done && op_div_reg && div_ovf |=> overflow_flag_reg && dest_low_byte_reg == $past(op_lo_reg)) else $error("dividend lost"); // [RULE8]
   div_result_a : assert property (@(posedge clock) disable iff (reset)
      done && op_div_reg && !div_ovf |=> dest_high_byte_reg == $past(remainder)) else $error("bad remainder"); // [RULE10]
   zero_flag_a : assert property (@(posedge clock) disable iff (reset)
      done && !op_div_reg |=> zero_flag_reg == (dest_low_byte_reg == 8'h00 && dest_high_byte_reg == 8'h00)) else $error("zero flag wrong"); // [RULE14]
   neg_flag_a : assert property (@(posedge clock) disable iff (reset)
      done && !op_div_reg |=> negative_flag_reg == dest_high_byte_reg[7]) else $error("negative flag wrong"); // [RULE12]
   src_hold_a : assert property (@(posedge clock) disable iff (reset)
      !(wr_strobe && (addr == `IMDU_ADDR_SRC_LO || addr == `IMDU_ADDR_SRC_HI)) |=> $stable(source_operand_reg)) else $error("source changed"); // [RULE3]

   // ==========================================================
   // checks on the sequencer
   // a load that is not overlapped by a new start ends the run
   sequence load_s;
      done && !start;
   endsequence

   load_idle_a : assert property (@(posedge clock) disable iff (reset) // [RULE5]
      load_s |=> !busy) else $error("busy after load");
   busy_hold_a : assert property (@(posedge clock) disable iff (reset) // [RULE5]
      busy && !done |=> busy) else $error("busy dropped early");
   idle_hold_a : assert property (@(posedge clock) disable iff (reset) // [RULE4]
      !busy && !start |=> !busy) else $error("busy without start");
   cnt_bound_a : assert property (@(posedge clock) disable iff (reset) // [RULE6]
      busy |-> cnt_reg < `IMDU_OP_CYCLES) else $error("counter past end");
   reset_clear_a : assert property (@(posedge clock) // [RULE15]
      reset |=> !busy && !negative_flag_reg && !overflow_flag_reg && !zero_flag_reg && rdata == `IMDU_NIB_ZERO)
      else $error("reset did not clear");

   // operands and mode are copied on the start edge
   latch_ops_a : assert property (@(posedge clock) disable iff (reset) // [RULE6]
      start |=> op_lo_reg == $past(dest_low_byte_reg) && op_hi_reg == $past(dest_high_byte_reg))
      else $error("operands not latched");
   latch_src_a : assert property (@(posedge clock) disable iff (reset) // [RULE2]
      start |=> op_src_reg == $past(source_operand_reg)) else $error("source not latched");
   latch_mode_a : assert property (@(posedge clock) disable iff (reset) // [RULE4]
      start |=> op_div_reg == $past(wdata[`IMDU_BIT_START])) else $error("mode not latched");

   // ==========================================================
   // checks on the results
   mul_low_a : assert property (@(posedge clock) disable iff (reset) // [RULE7]
      done && !op_div_reg |=> dest_low_byte_reg == $past(product[7:0])) else $error("bad product low byte");
   div_quot_a : assert property (@(posedge clock) disable iff (reset) // [RULE7]
      done && op_div_reg && !div_ovf |=> dest_low_byte_reg == $past(quot_full[7:0])) else $error("bad quotient");
   div_flags_a : assert property (@(posedge clock) disable iff (reset) // [RULE19]
      done && op_div_reg && !div_ovf
      |=> negative_flag_reg == dest_low_byte_reg[7] && zero_flag_reg == (dest_low_byte_reg == 8'h00)
          && !overflow_flag_reg) else $error("division flags wrong");
   div_keep_hi_a : assert property (@(posedge clock) disable iff (reset) // [RULE11]
      done && op_div_reg && div_ovf |=> dest_high_byte_reg == $past(op_hi_reg)) else $error("dividend high lost");
   ovf_flags_a : assert property (@(posedge clock) disable iff (reset) // [RULE19]
      done && op_div_reg && div_ovf
      |=> negative_flag_reg == dest_low_byte_reg[7] && zero_flag_reg == (dest_low_byte_reg == 8'h00))
      else $error("overflow flags wrong");
   div_zero_a : assert property (@(posedge clock) disable iff (reset) // [RULE20]
      done && op_div_reg && op_src_reg == 8'h00 |=> overflow_flag_reg) else $error("zero divisor missed");

   // ==========================================================
   // checks on the register port
   // read data stands until the next enabled edge after the strobe and is zero otherwise
   rd_idle_a : assert property (@(posedge clock) disable iff (reset)
      clock_enable && !rd_strobe |=> rdata == `IMDU_NIB_ZERO) else $error("read data not cleared");
   rd_ctrl_a : assert property (@(posedge clock) disable iff (reset) // [RULE5]
      clock_enable && rd_strobe && addr == `IMDU_ADDR_CTRL
      |=> rdata == {$past(negative_flag_reg), $past(overflow_flag_reg), $past(zero_flag_reg), $past(busy)})
      else $error("control read wrong");
   rd_src_a : assert property (@(posedge clock) disable iff (reset) // [RULE1]
      clock_enable && rd_strobe && addr == `IMDU_ADDR_SRC_LO |=> rdata == $past(source_operand_reg[3:0]))
      else $error("source read wrong");
   src_wr_a : assert property (@(posedge clock) disable iff (reset) // [RULE3]
      clock_enable && wr_strobe && addr == `IMDU_ADDR_SRC_HI |=> source_operand_reg[7:4] == $past(wdata))
      else $error("source write lost");
   dest_wr_a : assert property (@(posedge clock) disable iff (reset) // [RULE1]
      clock_enable && wr_strobe && !done && addr == `IMDU_ADDR_DLO_LO
      |=> dest_low_byte_reg[3:0] == $past(wdata)) else $error("destination write lost");
   dest_hi_wr_a : assert property (@(posedge clock) disable iff (reset) // [RULE1]
      clock_enable && wr_strobe && !done && addr == `IMDU_ADDR_DHI_HI
      |=> dest_high_byte_reg[7:4] == $past(wdata)) else $error("destination high write lost");
   flag_wr_a : assert property (@(posedge clock) disable iff (reset) // [RULE12] [RULE13] [RULE14]
      clock_enable && wr_strobe && !done && addr == `IMDU_ADDR_CTRL
      |=> $stable({negative_flag_reg, overflow_flag_reg, zero_flag_reg})) else $error("flag written by bus");

   // ==========================================================
   // checks on clock enable
   // nothing may move while the enable is low
   freeze_seq_a : assert property (@(posedge clock) disable iff (reset)
      !clock_enable |=> $stable(state_reg) && $stable(cnt_reg) && $stable(rdata)) else $error("state moved while frozen");
   freeze_flags_a : assert property (@(posedge clock) disable iff (reset)
      !clock_enable |=> $stable({negative_flag_reg, overflow_flag_reg, zero_flag_reg})) else $error("flags moved while frozen");
   freeze_src_a : assert property (@(posedge clock) disable iff (reset) // [RULE3]
      !clock_enable |=> $stable(source_operand_reg)) else $error("source moved while frozen");
endmodule // imdu_unit

// File: test/imdu_cpu_model.sv
`timescale 1ns/100ps
`include "imdu_map.svh"
// ==========================================================
// cpu side of the register port
module imdu_cpu_model (
   // clock
   input  wire logic        clock,
   // register port
   output logic      [15:0] addr,
   output logic      [3:0]  wdata,
   output logic             wr_strobe,
   output logic             rd_strobe,
   input  wire logic [3:0]  rdata,
   // status
   input  wire logic        busy
);
   // bus idle at time zero
   initial begin
      addr      = 16'hff87;
      wdata     = 4'h0;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
   end

   // one write or read; released lines do not keep their last value
   task automatic access(input logic w, input logic [15:0] a, input logic [3:0] d, output logic [3:0] q);
      @(posedge clock);
      addr      <= a;
      wdata     <= d;
      wr_strobe <= w;
      rd_strobe <= !w;
      @(posedge clock);
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      addr      <= ~a;
      wdata     <= ~d;
      #1 q = rdata;
   endtask

   // start an operation and keep off the results until it ends
   task automatic run(input logic [3:0] c, output int n);
      logic [3:0] q;
      access(1'b1, `IMDU_ADDR_CTRL, c, q);
      n = 0;
      while (busy === 1'b1 && n < 40) begin
         n++;
         @(posedge clock);
         #1;
      end
   endtask
endmodule // imdu_cpu_model

// File: test/integer_mul_div_unit_tb.sv
`timescale 1ns/100ps
`include "imdu_map.svh"
module integer_mul_div_unit_tb;
   // ==========================================================
   // one operation: source, dest low, dest high, control write, expected low, high, flags
   typedef struct packed {
      logic [7:0] src;
      logic [7:0] dl;
      logic [7:0] dh;
      logic [3:0] ctl;
      logic [7:0] rl;
      logic [7:0] rh;
      logic [3:0] fl;
   } imdu_row_t;
   localparam imdu_row_t ROWS [12] = '{
      '{8'h64, 8'h00, 8'hff, 4'he, 8'h00, 8'h00, 4'h2}, '{8'h64, 8'h16, 8'h1a, 4'h1, 8'h42, 8'h4e, 4'h0},
      '{8'h64, 8'h2c, 8'h33, 4'h1, 8'h83, 8'h00, 4'h8}, '{8'h58, 8'h64, 8'hff, 4'h0, 8'h60, 8'h22, 4'h0},
      '{8'h58, 8'hc8, 8'h00, 4'h0, 8'hc0, 8'h44, 4'h0}, '{8'h58, 8'h00, 8'h00, 4'h1, 8'h00, 8'h00, 4'h2},
      '{8'ha5, 8'hc8, 8'h12, 4'h0, 8'he8, 8'h80, 4'h8}, '{8'h13, 8'h68, 8'h24, 4'h1, 8'h68, 8'h24, 4'h4},
      '{8'h13, 8'h02, 8'h55, 4'h0, 8'h26, 8'h00, 4'h0}, '{8'h13, 8'h24, 8'h00, 4'h1, 8'h01, 8'h11, 4'h0},
      '{8'h13, 8'h68, 8'h11, 4'h1, 8'hea, 8'h0a, 4'h8}, '{8'h00, 8'h34, 8'h12, 4'hf, 8'h34, 8'h12, 4'h4}};
   logic        clock;
   logic        reset;
   logic        clock_enable;
   logic [15:0] addr;
   logic [3:0]  wdata;
   logic        wr_strobe;
   logic        rd_strobe;
   logic [3:0]  rdata;
   logic        busy;
   int          n_errors;
   int          n_checks;

   // design and cpu model
   imdu_unit u_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable), .addr(addr), .wdata(wdata),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .busy(busy));
   imdu_cpu_model u_cpu (.clock(clock), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rdata(rdata), .busy(busy));

   // clock at 100 MHz
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // compare one value
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   // byte access as two nibbles, low nibble first
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      logic [3:0] q;
      u_cpu.access(1'b1, a, d[3:0], q);
      u_cpu.access(1'b1, a + 16'h0001, d[7:4], q);
   endtask
   task automatic rd8(input logic [15:0] a, output logic [7:0] d);
      u_cpu.access(1'b0, a, 4'h0, d[3:0]);
      u_cpu.access(1'b0, a + 16'h0001, 4'h0, d[7:4]);
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // watchdog
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      logic [7:0] b;
      logic [3:0] q;
      int         n;
      n_errors = 0;
      n_checks = 0;
      reset = 1'b1;
      clock_enable = 1'b1;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      u_cpu.access(1'b0, `IMDU_ADDR_CTRL, 4'h0, q);
      chk(8'h00, {4'h0, q});
      foreach (ROWS[i]) begin
         if (i == 0 || ROWS[i].src !== ROWS[i - 1].src) wr8(`IMDU_ADDR_SRC_LO, ROWS[i].src);
         wr8(`IMDU_ADDR_DLO_LO, ROWS[i].dl);
         wr8(`IMDU_ADDR_DHI_LO, ROWS[i].dh);
         u_cpu.run(ROWS[i].ctl, n);
         chk(8'd10, n[7:0]);
         rd8(`IMDU_ADDR_DLO_LO, b);
         chk(ROWS[i].rl, b);
         rd8(`IMDU_ADDR_DHI_LO, b);
         chk(ROWS[i].rh, b);
         u_cpu.access(1'b0, `IMDU_ADDR_CTRL, 4'h0, q);
         chk({4'h0, ROWS[i].fl}, {4'h0, q});
      end
      // unmapped address reads zero
      u_cpu.access(1'b1, 16'hff87, 4'h5, q);
      u_cpu.access(1'b0, 16'hff87, 4'h0, q);
      chk(8'h00, {4'h0, q});
      // a write while clock enable is low is dropped
      u_cpu.access(1'b1, `IMDU_ADDR_SRC_LO, 4'h0, q);
      @(posedge clock);
      clock_enable <= 1'b0;
      u_cpu.access(1'b1, `IMDU_ADDR_SRC_LO, 4'h9, q);
      @(posedge clock);
      clock_enable <= 1'b1;
      u_cpu.access(1'b0, `IMDU_ADDR_SRC_LO, 4'h0, q);
      chk(8'h00, {4'h0, q});
      // reset in mid operation clears start bit and flags
      u_cpu.access(1'b1, `IMDU_ADDR_CTRL, 4'h1, q);
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      #1 chk(8'h00, {7'h00, busy});
      u_cpu.access(1'b0, `IMDU_ADDR_CTRL, 4'h0, q);
      chk(8'h00, {4'h0, q});
      wrap_up();
   end
endmodule // integer_mul_div_unit_tb
